/* File: pkg/pcd_pkg.sv */
// Purpose: shared types and constants of the programmable clock divider sequencer
// Assumes: one 20 MHz system clock; all clock levels are modelled as sampled signals
// Notes:   counts are in master-clock rising edges unless stated otherwise
package pcd_pkg;

   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int          RATIO_W      = 9;              // programmed ratio field
   localparam int          CNT_W        = 10;             // divider counter, holds up to 513
   localparam logic [9:0]  DIV_OFFSET   = 10'h002;        // divisor = field + 2
   localparam logic [9:0]  DIV_MAX      = 10'h201;        // forced divisor during settling (513)
   localparam logic [8:0]  STAB_CYCLES  = 9'h100;         // settling wait in master-clock cycles
   localparam logic [8:0]  STAB_LAST    = 9'h0FF;         // last count of the settling wait
   localparam logic [8:0]  RATIO_RESET  = 9'h000;         // ratio value before first capture

   // ----------------------------------------------------------------
   // configuration word, captured once at power-on
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ref_drive_off_bit;    // 1: reference pin high impedance
      logic pin_function_bit;     // 1: shared pin is power-down, 0: source select
      logic prescale_ratio_bit;   // 0: divide by 4, 1: divide by 2
      logic prescale_skip_bit;    // 1: prescaler bypassed
      logic bypass_all_scaling;   // 1: selected reference straight out
      logic ext_select_bit;       // 1: outside reference, 0: on-chip oscillator
   } pcd_cfg_t;

   localparam pcd_cfg_t CFG_RESET = '{default: 1'b0};

   // power sequencer, gray along init-settle-run-shutdown
   typedef enum logic [2:0] {
      PS_INIT     = 3'h0,
      PS_STAB     = 3'h1,
      PS_EN_REF   = 3'h3,
      PS_RUN      = 3'h2,
      PS_DIS_MAIN = 3'h6,
      PS_DIS_REF  = 3'h7,
      PS_OFF      = 3'h5
   } pcd_pwr_t;

   // reference selector, gray from RS_INT through RS_TO_INT; the step back to RS_INT flips two bits
   typedef enum logic [2:0] {
      RS_INT     = 3'h0,
      RS_TO_EXT  = 3'h1,
      RS_TO_EXT2 = 3'h3,
      RS_EXT     = 3'h2,
      RS_TO_INT  = 3'h6
   } pcd_rsel_t;

endpackage

/* File: logic/pcd_core.sv */
// Purpose: reference mux, prescaler, 9-bit divider and enabling sequencer
// Assumes: pins asynchronous to clk; clock levels are sampled and rebuilt on clk
// Notes:   on-chip oscillator toggles every clk, so it runs at half the clk rate
`timescale 1ns/1ps

module pcd_core
   import pcd_pkg::*;
(
   input  wire logic                 clk,                    // 20 MHz system clock
   input  wire logic                 rst_n,                  // power-on reset, active low
   input  wire pcd_cfg_t             cfg_stored,             // stored configuration bits
   input  wire logic [RATIO_W-1:0]   ratio_word,             // stored ratio field
   input  wire logic                 output_enable,          // main output enable, high runs
   input  wire logic                 shared_power_select_pin,// select or power-down pin
   input  wire logic                 outside_ref_clock,      // outside reference level
   output logic                      main_out,               // divided clock, registered
   output logic                      main_oe_n,              // main pin driven when low
   output logic                      reference_clock_pin,    // master clock copy, registered
   output logic                      ref_oe_n,               // reference pin driven when low
   output logic                      osc_running             // oscillator and buffers on
);

   // ----------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------
   typedef struct packed {
      pcd_pwr_t             pwr;
      pcd_rsel_t            rsel;
      pcd_cfg_t             cfg;
      logic [RATIO_W-1:0]   ratio;
      logic                 osc;
      logic [1:0]           presc;
      logic                 int_prev;
      logic                 mclk;
      logic                 mclk_d;
      logic                 oe_s1;
      logic                 oe_s2;
      logic                 pin_s1;
      logic                 pin_s2;
      logic                 oe_smp;
      logic                 bgate;
      logic [CNT_W-1:0]     cnt;
      logic [8:0]           stab;
      logic                 main_out;
      logic                 ref_en;
      logic                 ref_pin;
   } pcd_state_t;

   pcd_state_t       s_reg;
   pcd_state_t       s_next;
   logic             osc_on;
   logic             force_max;
   logic             scaled_internal_ref;
   logic             ext_lvl;
   logic             want_ext;
   logic             int_fall;
   logic             int_rise;
   logic             mclk_v;
   logic             mrise;
   logic             run_now;
   logic             pd_req;
   logic             main_en;
   logic [CNT_W-1:0] div_n;
   logic [CNT_W-1:0] high_len;
   logic [CNT_W-1:0] cnt_inc;
   logic             bgate_v;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      // two-stage sampling of the asynchronous pins
      s_next.oe_s1  = output_enable;
      s_next.oe_s2  = s_reg.oe_s1;
      s_next.pin_s1 = shared_power_select_pin;
      s_next.pin_s2 = s_reg.pin_s1;

      // oscillator and input buffer stop in init and off
      osc_on      = (s_reg.pwr != PS_INIT) && (s_reg.pwr != PS_OFF);
      force_max   = (s_reg.pwr == PS_STAB);
      main_en     = (s_reg.pwr == PS_RUN);
      pd_req      = s_reg.cfg.pin_function_bit && !s_reg.pin_s2;
      s_next.osc  = osc_on ? !s_reg.osc : 1'b0;
      if (!osc_on) begin
         s_next.presc = 2'h0;
      end else if (!s_reg.osc) begin
         s_next.presc = s_reg.presc + 2'h1;
      end

      // prescaler mux; settling forces the slowest ratio unless all scaling is bypassed
      if (s_reg.cfg.bypass_all_scaling || (s_reg.cfg.prescale_skip_bit && !force_max)) begin
         scaled_internal_ref = s_reg.osc;
      end else if (s_reg.cfg.prescale_ratio_bit && !force_max) begin
         scaled_internal_ref = s_reg.presc[0];
      end else begin
         scaled_internal_ref = s_reg.presc[1];
      end
      ext_lvl  = outside_ref_clock && osc_on;
      // select role overrides the stored source bit
      want_ext = s_reg.cfg.pin_function_bit ? s_reg.cfg.ext_select_bit : !s_reg.pin_s2;
      s_next.int_prev = scaled_internal_ref;
      int_fall = s_reg.int_prev && !scaled_internal_ref;
      int_rise = !s_reg.int_prev && scaled_internal_ref;

      // glitch-free reference switch
      mclk_v = 1'b0;
      case (s_reg.rsel)
         RS_INT: begin
            mclk_v = scaled_internal_ref;
            if (want_ext && int_fall) begin
               s_next.rsel = RS_TO_EXT;
               mclk_v      = 1'b0;
            end
         end
         RS_TO_EXT: begin
            // internal low phase is the half-period hold
            if (int_rise) begin
               s_next.rsel = RS_TO_EXT2;
            end
         end
         RS_TO_EXT2: begin
            if (!ext_lvl) begin
               s_next.rsel = RS_EXT;
            end
         end
         RS_EXT: begin
            mclk_v = ext_lvl;
            // level triggered: a stuck-high outside clock never lets go
            if (!want_ext && !ext_lvl) begin
               s_next.rsel = RS_TO_INT;
            end
         end
         RS_TO_INT: begin
            if (int_fall) begin
               s_next.rsel = RS_INT;
            end
         end
         default: begin
            s_next.rsel = RS_INT;
         end
      endcase
      s_next.mclk   = mclk_v;
      s_next.mclk_d = s_reg.mclk;
      mrise = s_reg.mclk && !s_reg.mclk_d;

      // divider: high for the first ceil(N/2) master periods
      // limitation: a ratio change after power-on is ignored until the next reset
      div_n    = force_max ? DIV_MAX : ({1'b0, s_reg.ratio} + DIV_OFFSET);
      high_len = div_n - {1'b0, div_n[CNT_W-1:1]};
      cnt_inc  = (s_reg.cnt + 10'h001 >= div_n) ? 10'h000 : s_reg.cnt + 10'h001;
      run_now  = s_reg.oe_s2 && main_en;
      bgate_v  = s_reg.bgate;
      if (mrise) begin
         s_next.oe_smp = s_reg.oe_s2;
         if (!s_reg.cfg.bypass_all_scaling) begin
            if (!run_now && !s_reg.main_out) begin
               s_next.cnt      = 10'h000;
               s_next.main_out = 1'b0;
            end else begin
               // a pulse already begun always runs to its end
               s_next.main_out = (s_reg.cnt < high_len);
               s_next.cnt      = cnt_inc;
            end
         end
      end
      if (s_reg.cfg.bypass_all_scaling) begin
         // gate moves only as the master clock rises; one edge late by design
         if (mclk_v && !s_reg.mclk) begin
            bgate_v = s_reg.oe_smp && main_en;
         end
         s_next.bgate    = bgate_v;
         s_next.main_out = mclk_v && bgate_v;
         s_next.cnt      = 10'h000;
      end

      // power sequencer
      case (s_reg.pwr)
         PS_INIT: begin
            s_next.cfg   = cfg_stored;
            s_next.ratio = ratio_word;
            s_next.stab  = 9'h000;
            s_next.pwr   = PS_STAB;
         end
         PS_STAB: begin
            if (pd_req) begin
               s_next.pwr = PS_DIS_MAIN;
            end else if (mrise) begin
               if (s_reg.stab == STAB_LAST) begin
                  s_next.pwr = PS_EN_REF;
               end else begin
                  s_next.stab = s_reg.stab + 9'h001;
               end
            end
         end
         PS_EN_REF: begin
            // enable the copy only while the master clock is low
            if (pd_req) begin
               s_next.pwr = PS_DIS_MAIN;
            end else if (!mclk_v) begin
               s_next.ref_en = 1'b1;
               s_next.pwr    = PS_RUN;
            end
         end
         PS_RUN: begin
            if (pd_req) begin
               s_next.pwr = PS_DIS_MAIN;
            end
         end
         PS_DIS_MAIN: begin
            // outside bypass the counter clears only at a master edge, so this wait can span a period
            if (!s_reg.main_out && (s_reg.cnt == 10'h000)) begin
               s_next.pwr = PS_DIS_REF;
            end
         end
         PS_DIS_REF: begin
            if (!mclk_v) begin
               s_next.ref_en = 1'b0;
               s_next.pwr    = PS_OFF;
            end
         end
         PS_OFF: begin
            // wake restarts the full settling wait at forced maximum divide
            if (!pd_req) begin
               s_next.stab = 9'h000;
               s_next.pwr  = PS_STAB;
            end
         end
         default: begin
            s_next.pwr = PS_INIT;
         end
      endcase
      s_next.ref_pin = mclk_v && s_next.ref_en;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // pin synchronisers start at the idle high level, so no false power-down follows reset
         s_reg <= '{pwr: PS_INIT, rsel: RS_INT, cfg: CFG_RESET, ratio: RATIO_RESET,
                    cnt: 10'h000, stab: 9'h000, presc: 2'h0, pin_s1: 1'b1, pin_s2: 1'b1,
                    default: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state record
   assign main_out            = s_reg.main_out;
   assign main_oe_n           = !((s_reg.pwr == PS_RUN) || (s_reg.pwr == PS_DIS_MAIN));
   assign reference_clock_pin = s_reg.ref_pin;
   assign ref_oe_n            = s_reg.cfg.ref_drive_off_bit || !s_reg.ref_en;
   assign osc_running         = osc_on;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // output gating, divider and settling length

   ref_drive_off_a: assert property (s_reg.cfg.ref_drive_off_bit |-> ref_oe_n)
      else $error("reference pin driven with drive-off set");
   enable_low_hold_a: assert property (mrise && !run_now && !s_reg.main_out
         && !s_reg.cfg.bypass_all_scaling |=> !main_out && s_reg.cnt == 10'h000)
      else $error("main output or counter not held while disabled");
   first_rise_a: assert property (mrise && run_now && !s_reg.main_out && s_reg.cnt == 10'h000
         && !s_reg.cfg.bypass_all_scaling |=> main_out)
      else $error("main output did not rise after enable");
   no_truncation_a: assert property ($fell(main_out) && !s_reg.cfg.bypass_all_scaling
         |-> $past(mrise))
      else $error("main pulse ended off a master edge");
   pd_outputs_off_a: assert property (s_reg.pwr == PS_DIS_REF |-> !main_out && main_oe_n)
      else $error("main output active in reference shutdown");
   settle_length_a: assert property ($rose(s_reg.pwr == PS_EN_REF) && $past(s_reg.pwr) == PS_STAB
         |-> $past(s_reg.stab) == STAB_LAST)
      else $error("settling wait length wrong");
   // reference switching, divisor and prescaler ratio
   switch_back_a: assert property (s_reg.rsel == RS_EXT && s_reg.pin_s2
         && !s_reg.cfg.pin_function_bit && !ext_lvl |=> s_reg.rsel == RS_TO_INT)
      else $error("switch to internal not started");
   switch_hold_low_a: assert property (s_reg.rsel inside {RS_TO_EXT, RS_TO_EXT2, RS_TO_INT}
         |-> !s_reg.mclk && !reference_clock_pin)
      else $error("master clock not held low in switch");
   divisor_value_a: assert property (!force_max |-> s_reg.cnt < {1'b0, s_reg.ratio} + DIV_OFFSET)
      else $error("divisor not field plus two");
   ratio_two_a: assert property (!s_reg.cfg.bypass_all_scaling && !s_reg.cfg.prescale_skip_bit
         && s_reg.cfg.prescale_ratio_bit && !force_max |-> scaled_internal_ref == s_reg.presc[0])
      else $error("prescaler not dividing by two");

   // sequencing and configuration
   gate_on_master_a: assert property (!s_reg.cfg.bypass_all_scaling && !mrise
         |=> $stable(main_out))
      else $error("main output moved off a master edge");
   config_frozen_a: assert property (s_reg.pwr != PS_INIT
         |=> $stable(s_reg.cfg) && $stable(s_reg.ratio))
      else $error("configuration changed after power-on");
   settle_quiet_a: assert property (s_reg.pwr == PS_STAB |-> main_oe_n && ref_oe_n && !main_out)
      else $error("outputs enabled before settling ended");
   settle_forced_a: assert property (s_reg.pwr == PS_STAB |-> div_n == DIV_MAX && s_reg.cnt == 10'h000)
      else $error("divider not forced and cleared in settling");
   off_quiet_a: assert property (s_reg.pwr == PS_OFF
         |-> !osc_running && ref_oe_n && !reference_clock_pin && !main_out)
      else $error("oscillator or outputs active in power-down");

   reach_off_c:   cover property (s_reg.pwr == PS_DIS_REF ##1 s_reg.pwr == PS_OFF);
   reach_ext_c:   cover property (s_reg.rsel == RS_TO_EXT2 ##1 s_reg.rsel == RS_EXT);
   bypass_out_c:  cover property (s_reg.cfg.bypass_all_scaling && $rose(main_out));
   wake_c:        cover property (s_reg.pwr == PS_OFF ##1 s_reg.pwr == PS_STAB);
   gated_c:       cover property (mrise && !run_now && !s_reg.main_out && s_reg.pwr == PS_RUN);

endmodule

/* File: verification/pcd_board_model.sv */
// Purpose: board-side source of the outside reference clock
// Assumes: free-running oscillator on the board, phase unrelated to clk
// Notes:   half period is a parameter so slow and fast boards can be tried
`timescale 1ns/1ps

module pcd_board_model #(
   parameter realtime HALF_NS = 250.0                 // half period of the board clock
) (
   output logic       outside_ref_clock               // clock into the reference input
);
   // ----------------------------------------------------------------
   // board oscillator
   // ----------------------------------------------------------------
   // offset start keeps its edges off the clk edges
   initial begin
      outside_ref_clock = 1'b0;
      #13.0;
      forever begin
         #(HALF_NS);
         outside_ref_clock = ~outside_ref_clock;
      end
   end
endmodule

/* File: verification/pcd_core_bench.sv */
// Purpose: self-checking bench for the clock divider sequencer
// Assumes: internal oscillator is clk/2, settling runs at forced divide by four except in bypass or on the outside clock
// Notes:   periods are measured in clk cycles between main output rises
`timescale 1ns/1ps

module pcd_core_bench;
   import pcd_pkg::*;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   pcd_cfg_t         cfg_stored = CFG_RESET;
   logic [RATIO_W-1:0] ratio_word = RATIO_RESET;
   logic             output_enable = 1'b1;
   logic             shared_power_select_pin = 1'b1;
   logic             outside_ref_clock;
   logic             main_out, main_oe_n, reference_clock_pin, ref_oe_n, osc_running;
   logic             prev = 1'b0;
   logic             prev_ref = 1'b0;
   int               ref_rises = 0;
   int               fail_count = 0, samples_checked = 0;
   int               cyc = 0, last_rise = 0, per = 0, high_w = 0, rises = 0;

   pcd_core i_pcd_core (.clk(clk), .rst_n(rst_n), .cfg_stored(cfg_stored), .ratio_word(ratio_word),
      .output_enable(output_enable), .shared_power_select_pin(shared_power_select_pin),
      .outside_ref_clock(outside_ref_clock), .main_out(main_out), .main_oe_n(main_oe_n),
      .reference_clock_pin(reference_clock_pin), .ref_oe_n(ref_oe_n), .osc_running(osc_running));
   pcd_board_model #(.HALF_NS(250.0)) i_pcd_board_model (.outside_ref_clock(outside_ref_clock));

   // ----------------------------------------------------------------
   // clock and output monitor
   // ----------------------------------------------------------------
   initial begin
      forever #25 clk = ~clk;
   end

   // period and high width of the main output, counted in clk cycles
   // sampled on the falling edge, where the registered outputs have settled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      prev <= main_out;
      prev_ref <= reference_clock_pin;
      if (reference_clock_pin === 1'b1 && prev_ref === 1'b0) ref_rises <= ref_rises + 1;
      if (main_out === 1'b1 && prev === 1'b0) begin
         per <= cyc - last_rise;
         last_rise <= cyc;
         rises <= rises + 1;
      end
      if (main_out === 1'b0 && prev === 1'b1) high_w <= cyc - last_rise;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_num(input string name, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   // config is only captured at power-on, so every mode needs a fresh reset
   task automatic power_up(input logic [5:0] c, input logic [8:0] r);
      int n;
      int mp;
      int st;
      // master period in clk while settling: board clock, bypassed osc, or forced divide by four
      mp = (c[4] && c[0]) ? 10 : (c[1] ? 2 : 8);
      st = int'(STAB_CYCLES);
      rst_n = 1'b0;
      cfg_stored = pcd_cfg_t'(c);
      ratio_word = r;
      output_enable = 1'b1;
      shared_power_select_pin = 1'b1;
      tick(16);
      rst_n = 1'b1;
      n = 0;
      while (main_oe_n !== 1'b0 && n < 3000) begin
         tick(1);
         n++;
      end
      check_bit("main_oe_n after settle", 1'b0, main_oe_n);
      check_num("settle length", 1, int'(n >= (st - 6) * mp && n <= (st + 6) * mp + 20));
   endtask

   task automatic expect_period(input string name, input int p);
      tick(2 * p + 40);
      check_num(name, p, per);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic sc_dividers;
      int n;
      power_up(6'h00, 9'h000);
      expect_period("period div 4N", 2 * 4 * int'(DIV_OFFSET));
      n = ref_rises;
      tick(80);
      check_num("reference clock rises", 10, ref_rises - n);
      ratio_word = 9'h1FF;
      expect_period("period after late change", 16);
      power_up(6'h08, 9'h001);
      expect_period("period div 2N", 2 * 2 * 3);
      power_up(6'h0C, 9'h003);
      expect_period("period skip", 2 * 5);
      power_up(6'h04, 9'h1FF);
      expect_period("period top divisor", 2 * 513);
      power_up(6'h22, 9'h1FF);
      expect_period("period bypass", 2);
      check_bit("ref_oe_n drive off", 1'b1, ref_oe_n);
   endtask

   task automatic sc_outside;
      power_up(6'h19, 9'h000);
      expect_period("period outside", 10 * 2);
   endtask

   task automatic sc_enable;
      int n, r;
      power_up(6'h00, 9'h000);
      n = 0;
      while (main_out !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      output_enable = 1'b0;
      tick(40);
      check_num("high width at disable", 8, high_w);
      check_bit("main_out disabled", 1'b0, main_out);
      r = rises;
      tick(64);
      check_num("rises while disabled", r, rises);
      output_enable = 1'b1;
      n = 0;
      while (rises == r && n < 40) begin
         tick(1);
         n++;
      end
      check_num("enable latency bound", 1, int'(n <= 20));
   endtask

   task automatic sc_select;
      power_up(6'h00, 9'h000);
      check_bit("ref_oe_n driven", 1'b0, ref_oe_n);
      shared_power_select_pin = 1'b0;
      expect_period("period select outside", 20);
      shared_power_select_pin = 1'b1;
      expect_period("period select internal", 16);
   endtask

   task automatic sc_power_down;
      int n;
      power_up(6'h10, 9'h000);
      shared_power_select_pin = 1'b0;
      tick(100);
      check_bit("main_oe_n down", 1'b1, main_oe_n);
      check_bit("main_out down", 1'b0, main_out);
      check_bit("ref_oe_n down", 1'b1, ref_oe_n);
      check_bit("reference_clock_pin down", 1'b0, reference_clock_pin);
      check_bit("osc_running down", 1'b0, osc_running);
      shared_power_select_pin = 1'b1;
      tick(1500);
      check_bit("osc_running wake", 1'b1, osc_running);
      check_bit("ref_oe_n settling", 1'b1, ref_oe_n);
      n = 0;
      while (main_oe_n !== 1'b0 && n < 1000) begin
         tick(1);
         n++;
      end
      check_bit("main_oe_n wake", 1'b0, main_oe_n);
      expect_period("period after wake", 16);
   endtask

   // ----------------------------------------------------------------
   // verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic final_report;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // all scenarios need about 23000 cycles, so over twice that cuts a hang
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      final_report;
   end

   initial begin
      tick(1);
      sc_dividers;
      sc_outside;
      sc_enable;
      sc_select;
      sc_power_down;
      final_report;
   end
endmodule
